// ===== inc/aces_pkg.sv
package aces_pkg;
  // Register offsets within the controller's parameter page
  localparam logic [7:0] OFF_TX_TMPL = 8'he0;
  localparam logic [7:0] OFF_INT_STATS = 8'he8;
  localparam logic [7:0] OFF_FILLER = 8'hea;
  localparam logic [7:0] OFF_EXT_STATS = 8'hf0;
  localparam logic [7:0] OFF_CTRL = 8'hc0;
  localparam logic [7:0] OFF_STATUS = 8'hc4;
  localparam logic [7:0] OFF_IRQ_CLR = 8'hc8;
  localparam logic [7:0] OFF_IRQ_EN = 8'hcc;
  localparam logic [7:0] OFF_SEQ_ERR_CNT = 8'hd0;
  localparam logic [7:0] OFF_PTR_ERR_CNT = 8'hd4;
  localparam logic [7:0] OFF_LOST_CNT = 8'hd8;
  // Adaptation type codes
  localparam logic [2:0] TYPE_BASIC = 3'h1;
  localparam logic [2:0] TYPE_CES = 3'h5;
  // Control register fields
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_FMT_BIT = 3;
  localparam int CTRL_SLIP_MASK_BIT = 4;
  // Status bit positions
  localparam int ST_SEQ_ERR = 0;
  localparam int ST_PTR_ERR = 1;
  localparam int ST_LOST = 2;
  localparam int ST_SLIP = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_W = 5;
  // Pointer and sequence number widths
  localparam int PTR_W = 7;
  localparam int SN_W = 3;
  localparam logic [3:0] DUMMY_BYTES = 4'h0;
  localparam logic [2:0] CTRL_RESET_TYPE = 3'h1;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aces_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [SN_W-1:0] sn;
    logic has_ptr;
    logic [PTR_W-1:0] ptr;
    logic ptr_par;
  } aces_rx_cell_t;

  typedef struct packed {
    logic valid;
    logic has_ptr;
    logic [PTR_W-1:0] ptr;
    logic ptr_par;
    logic dummy;
  } aces_tx_cell_t;
endpackage : aces_pkg

// ===== core/aces_core.sv
`timescale 1ns/1ps
// Operation
// - Basic type with structured format: make pointer parity on send, check it on receive.
// - Transmit busy keeps held pointer intact; cell sent later with same pointer.
// - Type code 001 basic, 101 emulation, chosen by software in control register.
// - On detected cell loss, set dummy flag on the delivered cell; no template pointer is used.
// - Count sequence number errors in a single counter, read back at offset 0xd0.
// - Slip interrupt mask zero suppresses slip interrupts.
// - Emulation type leaves transmit layout unchanged.
module aces_core (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire aces_pkg::aces_bus_req_t bus_in,
  output logic [31:0] rdata_out,
  input wire aces_pkg::aces_rx_cell_t rx_cell_in,
  input wire logic rx_slip_in,
  input wire logic tx_req_in,
  input wire logic [aces_pkg::PTR_W-1:0] tx_ptr_in,
  input wire logic tx_bd_ready_in,
  output aces_pkg::aces_tx_cell_t tx_cell_out,
  output aces_pkg::aces_tx_cell_t rx_dlv_out,
  output logic [aces_pkg::PTR_W-1:0] align_ptr_out,
  output logic irq_out
);
  function automatic logic odd_par(input logic [aces_pkg::PTR_W-1:0] p);
    odd_par = ~(^p);
  endfunction : odd_par

  // Held pointer wins over the live one
  function automatic logic [aces_pkg::PTR_W-1:0] pick_ptr(input logic held,
    input logic [aces_pkg::PTR_W-1:0] kept, input logic [aces_pkg::PTR_W-1:0] live);
    pick_ptr = held ? kept : live;
  endfunction : pick_ptr

  logic [31:0] tx_tmpl_reg;
  logic [15:0] int_stats_reg;
  logic [15:0] filler_reg;
  logic [31:0] ext_stats_reg;
  logic [4:0] ctrl_reg;
  logic [aces_pkg::ST_W-1:0] status_reg;
  logic [aces_pkg::ST_W-1:0] irq_en_reg;
  logic [15:0] seq_err_cnt_reg;
  logic [15:0] ptr_err_cnt_reg;
  logic [15:0] lost_cnt_reg;
  logic [aces_pkg::SN_W-1:0] exp_sn_reg;
  logic sn_valid_reg;
  logic [aces_pkg::PTR_W-1:0] held_ptr_reg;
  logic held_reg;
  logic [1:0] slip_sync_reg;
  logic slip_prev_reg;

  logic [2:0] type_sel;
  logic par_active;
  logic wr_clr;
  logic [aces_pkg::ST_W-1:0] ev;
  logic seq_err_ev;
  logic lost_ev;
  logic ptr_err_ev;
  logic slip_ev;
  logic busy_ev;
  logic rx_ptr_ok;
  logic [aces_pkg::SN_W-1:0] sn_plus;

  assign type_sel = ctrl_reg[aces_pkg::CTRL_TYPE_LSB +: 3];
  // Parity for both codes once structured format is on
  assign par_active = (type_sel == aces_pkg::TYPE_BASIC || type_sel == aces_pkg::TYPE_CES)
    && ctrl_reg[aces_pkg::CTRL_FMT_BIT];
  assign wr_clr = bus_in.wr && bus_in.addr == aces_pkg::OFF_IRQ_CLR;
  assign sn_plus = exp_sn_reg + 3'h1;

  // Receive sequence tracking
  assign seq_err_ev = rx_cell_in.valid && sn_valid_reg && rx_cell_in.sn != exp_sn_reg
    && rx_cell_in.sn != sn_plus;
  // One missing number means one dropped cell
  assign lost_ev = rx_cell_in.valid && sn_valid_reg && rx_cell_in.sn == sn_plus;
  assign rx_ptr_ok = !par_active || (odd_par(rx_cell_in.ptr) == rx_cell_in.ptr_par);
  assign ptr_err_ev = rx_cell_in.valid && rx_cell_in.has_ptr && !rx_ptr_ok;
  assign slip_ev = slip_sync_reg[1] && !slip_prev_reg
    && ctrl_reg[aces_pkg::CTRL_SLIP_MASK_BIT];
  assign busy_ev = tx_req_in && !tx_bd_ready_in && !held_reg;
  assign ev = {busy_ev, slip_ev, lost_ev, ptr_err_ev, seq_err_ev};

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_tmpl_reg <= 32'h0;
      int_stats_reg <= 16'h0;
      filler_reg <= 16'h0;
      ext_stats_reg <= 32'h0;
      ctrl_reg <= {2'h0, aces_pkg::CTRL_RESET_TYPE};
      irq_en_reg <= '0;
    end
    else if (clk_en_in && bus_in.wr)
    begin
      // Offsets taken relative to the page base
      unique case (bus_in.addr)
        aces_pkg::OFF_TX_TMPL: tx_tmpl_reg <= {bus_in.wdata[31:6], 6'h0};
        aces_pkg::OFF_INT_STATS: int_stats_reg <= {bus_in.wdata[15:4], 4'h0};
        aces_pkg::OFF_FILLER: filler_reg <= {bus_in.wdata[15:6], 6'h0};
        aces_pkg::OFF_EXT_STATS: ext_stats_reg <= {bus_in.wdata[31:4], 4'h0};
        aces_pkg::OFF_CTRL: ctrl_reg <= bus_in.wdata[4:0];
        aces_pkg::OFF_IRQ_EN: irq_en_reg <= bus_in.wdata[aces_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      status_reg <= '0;
    else if (clk_en_in)
      status_reg <= (status_reg & ~(wr_clr ? bus_in.wdata[aces_pkg::ST_W-1:0] : '0)) | ev;
  end

  assign irq_out = |(status_reg & irq_en_reg);

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      seq_err_cnt_reg <= 16'h0;
      ptr_err_cnt_reg <= 16'h0;
      lost_cnt_reg <= 16'h0;
    end
    else if (clk_en_in)
    begin
      if (seq_err_ev)
        seq_err_cnt_reg <= seq_err_cnt_reg + 16'h1;
      if (ptr_err_ev)
        ptr_err_cnt_reg <= ptr_err_cnt_reg + 16'h1;
      if (lost_ev)
        lost_cnt_reg <= lost_cnt_reg + 16'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      exp_sn_reg <= '0;
      sn_valid_reg <= 1'b0;
    end
    else if (clk_en_in && rx_cell_in.valid)
    begin
      exp_sn_reg <= rx_cell_in.sn + 3'h1;
      sn_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slip_sync_reg <= 2'h0;
      slip_prev_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      slip_sync_reg <= {slip_sync_reg[0], rx_slip_in};
      slip_prev_reg <= slip_sync_reg[1];
    end
  end

  // Receive delivery: dummy cell ahead of the arriving one is signalled by flag
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_dlv_out <= '0;
      align_ptr_out <= '0;
    end
    else if (clk_en_in)
    begin
      rx_dlv_out.valid <= rx_cell_in.valid;
      rx_dlv_out.has_ptr <= rx_cell_in.has_ptr && rx_ptr_ok;
      rx_dlv_out.ptr <= rx_cell_in.ptr;
      rx_dlv_out.ptr_par <= rx_cell_in.ptr_par;
      rx_dlv_out.dummy <= lost_ev;
      if (rx_cell_in.valid && rx_cell_in.has_ptr && rx_ptr_ok)
        align_ptr_out <= rx_cell_in.ptr;
    end
  end

  // Transmit: layout same for both codes, parity only added
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_cell_out <= '0;
      held_ptr_reg <= '0;
      held_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      tx_cell_out.valid <= 1'b0;
      if (tx_req_in && !tx_bd_ready_in && !held_reg)
      begin
        held_ptr_reg <= tx_ptr_in;
        held_reg <= 1'b1;
      end
      else if (tx_bd_ready_in && (held_reg || tx_req_in))
      begin
        tx_cell_out.valid <= 1'b1;
        tx_cell_out.has_ptr <= 1'b1;
        tx_cell_out.ptr <= pick_ptr(held_reg, held_ptr_reg, tx_ptr_in);
        tx_cell_out.ptr_par <= par_active ?
          odd_par(pick_ptr(held_reg, held_ptr_reg, tx_ptr_in)) : 1'b0;
        tx_cell_out.dummy <= 1'b0;
        held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 32'h0;
    else if (clk_en_in)
    begin
      rdata_out <= 32'h0;
      if (bus_in.rd)
      begin
        unique case (bus_in.addr)
          aces_pkg::OFF_TX_TMPL: rdata_out <= tx_tmpl_reg;
          aces_pkg::OFF_INT_STATS: rdata_out <= {16'h0, int_stats_reg};
          aces_pkg::OFF_FILLER: rdata_out <= {16'h0, filler_reg};
          aces_pkg::OFF_EXT_STATS: rdata_out <= ext_stats_reg;
          aces_pkg::OFF_CTRL: rdata_out <= {27'h0, ctrl_reg};
          aces_pkg::OFF_STATUS: rdata_out <= {27'h0, status_reg};
          aces_pkg::OFF_IRQ_EN: rdata_out <= {27'h0, irq_en_reg};
          aces_pkg::OFF_SEQ_ERR_CNT: rdata_out <= {16'h0, seq_err_cnt_reg};
          aces_pkg::OFF_PTR_ERR_CNT: rdata_out <= {16'h0, ptr_err_cnt_reg};
          aces_pkg::OFF_LOST_CNT: rdata_out <= {16'h0, lost_cnt_reg};
          default: rdata_out <= 32'h0;
        endcase
      end
    end
  end

  sequence s_busy_hold;
    tx_req_in && !tx_bd_ready_in && !held_reg;
  endsequence

  a_tx_parity_gen: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    tx_cell_out.valid && par_active |-> tx_cell_out.ptr_par == odd_par(tx_cell_out.ptr))
    else $error("transmit pointer parity wrong");
  a_busy_ptr_kept: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_busy_hold and clk_en_in |=> held_ptr_reg == $past(tx_ptr_in) && held_reg)
    else $error("busy pointer not held");
  a_type_basic_par: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    type_sel == aces_pkg::TYPE_BASIC && ctrl_reg[aces_pkg::CTRL_FMT_BIT] |-> par_active)
    else $error("parity off in basic type");
  a_lost_dummy_out: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && lost_ev |=> rx_dlv_out.dummy)
    else $error("dummy cell not inserted");
  a_seq_err_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && seq_err_ev |=> seq_err_cnt_reg == $past(seq_err_cnt_reg) + 16'h1)
    else $error("sequence error not counted");
  a_slip_masked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_reg[aces_pkg::CTRL_SLIP_MASK_BIT] |-> !slip_ev)
    else $error("slip event while masked");
  a_tx_layout_same: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    tx_cell_out.valid |-> tx_cell_out.has_ptr && !tx_cell_out.dummy)
    else $error("transmit layout changed");
  a_bad_ptr_blocked: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && ptr_err_ev |=> $stable(align_ptr_out) && status_reg[aces_pkg::ST_PTR_ERR])
    else $error("bad pointer used for alignment");

  sequence s_held_release;
    held_reg && tx_bd_ready_in;
  endsequence

  sequence s_rx_bad_ptr;
    rx_cell_in.valid && rx_cell_in.has_ptr && !rx_ptr_ok;
  endsequence

  sequence s_rx_good_ptr;
    rx_cell_in.valid && rx_cell_in.has_ptr && rx_ptr_ok;
  endsequence

  // Transmit checks
  a_held_sent: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_held_release and clk_en_in
    |=> tx_cell_out.valid && tx_cell_out.ptr == $past(held_ptr_reg))
    else $error("held pointer not sent");
  a_busy_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_busy_hold and clk_en_in
    |=> status_reg[aces_pkg::ST_BUSY])
    else $error("busy event not flagged");
  a_held_waits: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && held_reg && !tx_bd_ready_in
    |=> !tx_cell_out.valid)
    else $error("cell sent while descriptor busy");

  // Register checks
  a_type_other: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    type_sel != aces_pkg::TYPE_BASIC && type_sel != aces_pkg::TYPE_CES
    |-> !par_active)
    else $error("parity active for unknown type");
  a_ctrl_written: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && bus_in.wr && bus_in.addr == aces_pkg::OFF_CTRL
    |=> ctrl_reg == $past(bus_in.wdata[4:0]))
    else $error("control write lost");
  a_freeze_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !clk_en_in
    |=> $stable(status_reg) && $stable(ctrl_reg) && $stable(tx_cell_out))
    else $error("state moved while frozen");
  a_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && !bus_in.rd
    |=> rdata_out == 32'h0)
    else $error("read data without read");

  // Receive checks
  a_rx_par_check: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_rx_bad_ptr and clk_en_in
    |-> par_active && ptr_err_ev)
    else $error("receive parity not checked");
  a_lost_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && lost_ev
    |=> lost_cnt_reg == $past(lost_cnt_reg) + 16'h1)
    else $error("lost cell not counted");
  a_dummy_only_lost: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && !lost_ev
    |=> !rx_dlv_out.dummy)
    else $error("dummy cell without loss");
  a_seq_err_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && seq_err_ev
    |=> status_reg[aces_pkg::ST_SEQ_ERR])
    else $error("sequence error not flagged");
  a_slip_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    clk_en_in && slip_ev
    |=> status_reg[aces_pkg::ST_SLIP])
    else $error("slip not flagged");
  a_ptr_err_count: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_rx_bad_ptr and clk_en_in
    |=> ptr_err_cnt_reg == $past(ptr_err_cnt_reg) + 16'h1)
    else $error("pointer error not counted");
  a_good_ptr_used: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_rx_good_ptr and clk_en_in
    |=> align_ptr_out == $past(rx_cell_in.ptr))
    else $error("good pointer not used");
endmodule : aces_core

// ===== testbench/aces_far_node.sv
`timescale 1ns/1ps
module aces_far_node (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic send_in,
  input wire logic [aces_pkg::SN_W-1:0] sn_in,
  input wire logic [aces_pkg::PTR_W-1:0] ptr_in,
  input wire logic bad_par_in,
  output aces_pkg::aces_rx_cell_t cell_out
);
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cell_out <= '0;
    else if (send_in)
      cell_out <= {1'b1, sn_in, 1'b1, ptr_in, ~^ptr_in ^ bad_par_in};
    else
      // Idle clears valid and toggles the other fields, so a stale cell never looks valid
      cell_out <= {1'b0, ~cell_out[11:0]};
  end
endmodule : aces_far_node

// ===== testbench/aces_core_tb.sv
`timescale 1ns/1ps
module aces_core_tb;
  logic clk_sys_in, rst_n_in, rx_slip_in, tx_req_in, tx_bd_ready_in, irq_out;
  logic node_send, node_bad, rd_seen, clk_en_in;
  logic [2:0] node_sn;
  logic [6:0] tx_ptr_in, align_ptr_out, node_ptr, good_ptr;
  logic [31:0] rdata_out, lfsr_state;
  aces_pkg::aces_bus_req_t bus_in;
  aces_pkg::aces_rx_cell_t rx_cell_in;
  aces_pkg::aces_tx_cell_t tx_cell_out, rx_dlv_out;
  aces_pkg::aces_tx_cell_t dlv_q[$];
  aces_pkg::aces_tx_cell_t tx_q[$];
  logic [31:0] rd_q[$];
  int bad_count, total_checks;
  localparam logic [7:0] REG_OFF [4] = '{8'he0, 8'he8, 8'hea, 8'hf0};
  localparam logic [31:0] REG_MASK [4] = '{32'hffffffc0, 32'h0000fff0, 32'h0000ffc0, 32'hfffffff0};

  aces_core u_aces_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .rx_cell_in(rx_cell_in), .rx_slip_in(rx_slip_in),
    .tx_req_in(tx_req_in), .tx_ptr_in(tx_ptr_in), .tx_bd_ready_in(tx_bd_ready_in),
    .tx_cell_out(tx_cell_out), .rx_dlv_out(rx_dlv_out), .align_ptr_out(align_ptr_out),
    .irq_out(irq_out));
  aces_far_node u_aces_far_node (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .send_in(node_send), .sn_in(node_sn), .ptr_in(node_ptr), .bad_par_in(node_bad),
    .cell_out(rx_cell_in));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_cell(input string what, input aces_pkg::aces_tx_cell_t exp,
    input aces_pkg::aces_tx_cell_t got);
    if (!exp.has_ptr)
      exp[8:1] = got[8:1];
    cmp_word(what, {21'h0, exp}, {21'h0, got});
  endtask : cmp_cell

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  always @(posedge clk_sys_in)
    rd_seen <= bus_in.rd;

  always @(negedge clk_sys_in)
  begin
    if (rd_seen === 1'b1)
      cmp_word("rdata", rd_q.size() > 0 ? rd_q.pop_front() : 32'hx, rdata_out);
    if (rx_dlv_out.valid === 1'b1)
      cmp_cell("rx_dlv", dlv_q.size() > 0 ? dlv_q.pop_front() : '0, rx_dlv_out);
    if (tx_cell_out.valid === 1'b1)
      cmp_cell("tx_cell", tx_q.size() > 0 ? tx_q.pop_front() : '0, tx_cell_out);
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    bus_in <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys_in);
    bus_in <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_sys_in);
    bus_in <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys_in);
    bus_in <= '0;
    repeat (2) @(posedge clk_sys_in);
  endtask : rd

  task automatic chk_irq(input logic exp);
    @(negedge clk_sys_in);
    cmp_word("irq_out", {31'h0, exp}, {31'h0, irq_out});
  endtask : chk_irq

  task automatic slip_pulse();
    @(posedge clk_sys_in);
    rx_slip_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rx_slip_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
  endtask : slip_pulse

  task automatic rx_send(input logic [2:0] sn, input logic bad, input logic dmy);
    logic [6:0] p;
    lfsr_state = lfsr_next(lfsr_state);
    p = lfsr_state[6:0];
    if (!bad)
      good_ptr = p;
    dlv_q.push_back({1'b1, ~bad, p, ~^p, dmy});
    @(posedge clk_sys_in);
    {node_send, node_sn, node_ptr, node_bad} <= {1'b1, sn, p, bad};
    @(posedge clk_sys_in);
    node_send <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask : rx_send

  task automatic tx_send(input int stall);
    logic [6:0] p;
    lfsr_state = lfsr_next(lfsr_state);
    p = lfsr_state[6:0];
    tx_q.push_back({1'b1, 1'b1, p, ~^p, 1'b0});
    @(posedge clk_sys_in);
    {tx_req_in, tx_ptr_in, tx_bd_ready_in} <= {1'b1, p, stall == 0};
    @(posedge clk_sys_in);
    // A second request with another pointer while the first waits
    tx_ptr_in <= ~p;
    repeat (stall) @(posedge clk_sys_in);
    {tx_req_in, tx_bd_ready_in} <= 2'b01;
    repeat (4) @(posedge clk_sys_in);
  endtask : tx_send

  initial
  begin
    {rst_n_in, rx_slip_in, tx_req_in, node_send, node_bad} = '0;
    {bus_in, tx_ptr_in, node_sn, node_ptr, good_ptr} = '0;
    tx_bd_ready_in = 1'b1;
    clk_en_in = 1'b1;
    lfsr_state = 32'he817;
    bad_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(aces_pkg::OFF_CTRL, {29'h0, aces_pkg::CTRL_RESET_TYPE});
    for (int i = 0; i < 4; i++)
    begin
      lfsr_state = lfsr_next(lfsr_state);
      wr(REG_OFF[i], lfsr_state);
      rd(REG_OFF[i], lfsr_state & REG_MASK[i]);
    end
    rd(8'h10, 32'h0);
    rd(aces_pkg::OFF_IRQ_CLR, 32'h0);
    wr(aces_pkg::OFF_IRQ_EN, 32'h1f);
    slip_pulse();
    chk_irq(1'b0);
    wr(aces_pkg::OFF_CTRL, 32'h1d);
    slip_pulse();
    chk_irq(1'b1);
    wr(aces_pkg::OFF_IRQ_CLR, 32'h1f);
    chk_irq(1'b0);
    rx_send(3'h0, 1'b0, 1'b0);
    rx_send(3'h1, 1'b0, 1'b0);
    rx_send(3'h3, 1'b0, 1'b1);
    rx_send(3'h4, 1'b1, 1'b0);
    cmp_word("align_ptr", {25'h0, good_ptr}, {25'h0, align_ptr_out});
    rx_send(3'h7, 1'b0, 1'b0);
    rd(aces_pkg::OFF_STATUS, 32'h7);
    rd(aces_pkg::OFF_SEQ_ERR_CNT, 32'h1);
    rd(aces_pkg::OFF_PTR_ERR_CNT, 32'h1);
    rd(aces_pkg::OFF_LOST_CNT, 32'h1);
    wr(aces_pkg::OFF_IRQ_CLR, 32'h1f);
    tx_send(3);
    rd(aces_pkg::OFF_STATUS, 32'h10);
    tx_send(0);
    wr(aces_pkg::OFF_CTRL, 32'h19);
    tx_send(0);
    // Frozen clock enable must swallow this write
    clk_en_in <= 1'b0;
    wr(aces_pkg::OFF_CTRL, 32'h0);
    clk_en_in <= 1'b1;
    rd(aces_pkg::OFF_CTRL, 32'h19);
    cmp_word("queues", 32'h0, dlv_q.size() + tx_q.size() + rd_q.size());
    complete_run();
  end

  initial
  begin
    #(20 * 20000);
    bad_count++;
    complete_run();
  end
endmodule : aces_core_tb
